// ===== verilog/rcp_pkg.sv
// constants and types of the serial command port
package rcp_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int OVS = 16;
  localparam int RATE_4800 = 4800;
  localparam int RATE_9600 = 9600;
  localparam int RATE_19200 = 19200;
  localparam int RATE_38400 = 38400;
  localparam int RATE_115200 = 115200;
  localparam int CMD_MAX = 2048;
  localparam int FIFO_DEPTH = 8;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_TXDATA = 8'h08;
  localparam logic [7:0] REG_RXDATA = 8'h0c;
  localparam logic [7:0] REG_RXLEN = 8'h10;
  localparam logic [7:0] REG_CTRL = 8'h14;
  localparam int CFG_W = 14;
  localparam int CFG_BAUD = 0;
  localparam int CFG_DBITS = 3;
  localparam int CFG_STOP = 5;
  localparam int CFG_PAR = 7;
  localparam int CFG_TERM = 9;
  localparam int CFG_IF = 11;
  localparam int CFG_USB = 13;
  localparam logic [13:0] CFG_RST = 14'h0011;
  localparam int ST_READY = 0;
  localparam int ST_PERR = 1;
  localparam int ST_FERR = 2;
  localparam int ST_OVF = 3;
  localparam int ST_OVR = 4;
  localparam int ST_TXBUSY = 5;
  localparam int ST_RXBUSY = 6;
  localparam int ST_TXFULL = 7;
  localparam int ST_PEND = 8;
  localparam int CTRL_RELEASE = 0;
  typedef enum logic [1:0] {PAR_NONE = 2'b00, PAR_ODD = 2'b01,
    PAR_EVEN = 2'b10} rcp_par_t;
  typedef enum logic [1:0] {TERM_LF = 2'b00, TERM_CR = 2'b01,
    TERM_CR_LF = 2'b10} rcp_term_t;
  typedef enum logic [1:0] {IF_SERIAL = 2'b00, IF_USB = 2'b01,
    IF_LAN = 2'b10} rcp_if_t;
  typedef enum logic [2:0] {TX_IDLE = 3'b000, TX_START = 3'b001,
    TX_DATA = 3'b010, TX_PAR = 3'b011, TX_STOP = 3'b100} rcp_txs_t;
  typedef enum logic [2:0] {RX_IDLE = 3'b000, RX_START = 3'b001,
    RX_DATA = 3'b010, RX_PAR = 3'b011, RX_STOP = 3'b100} rcp_rxs_t;

  // oversample tick period minus one; rounds down, so a fast bit clock
  function automatic logic [7:0] baud_div(input logic [2:0] sel);
    int r;
    case (sel)
      3'h0: r = RATE_4800;
      3'h1: r = RATE_9600;
      3'h2: r = RATE_19200;
      3'h3: r = RATE_38400;
      default: r = RATE_115200;
    endcase
    return 8'(CLK_HZ / (r * OVS) - 1);
  endfunction
endpackage

// ===== verilog/rcp_top.sv
// serial command port: fifo, transmitter, receiver and command buffer
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
module rcp_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } rcp_fifo_st_t;
  rcp_fifo_st_t s_q, s_d;
  logic [W-1:0] mem [D];
  logic push, pop;

  assign o_in_ready = s_q.cnt != (AW+1)'(D);
  assign o_out_valid = s_q.cnt != '0;
  assign o_out_data = mem[s_q.rp];

  always_comb begin
    push = i_in_valid && o_in_ready;
    pop = o_out_valid && i_out_ready;
    s_d = s_q;
    if (push) begin
      s_d.wp = (s_q.wp == AW'(D-1)) ? '0 : s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = (s_q.rp == AW'(D-1)) ? '0 : s_q.rp + 1'b1;
    end
    s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem[s_q.wp] <= i_in_data;
    end
  end
endmodule

module rcp_top
  import rcp_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_rxd,
  output logic o_txd,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_tx_ready,
  output logic o_cmd_ready,
  output logic o_if_serial,
  output logic o_if_usb,
  output logic o_if_lan,
  output logic o_usb_vserial,
  output logic o_usb_tmc
);
  import rcp_pkg::*;
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic [CFG_W-1:0] cfg;
    logic [CFG_W-1:0] cfg_new;
    logic pend;
    logic [7:0] tick_cnt;
    rcp_rxs_t rst;
    logic [5:0] rcnt;
    logic [3:0] rbit;
    logic [7:0] rsh;
    logic rpar;
    logic rferr;
    rcp_txs_t tst;
    logic [5:0] tcnt;
    logic [3:0] tbit;
    logic [7:0] tsh;
    logic tpar;
    logic txd;
    logic [11:0] len;
    logic [11:0] rd_ptr;
    logic ready;
    logic prev_cr;
    logic perr;
    logic ferr;
    logic ovf;
    logic ovr;
    logic [31:0] rdata;
    logic rd_sel;
  } rcp_st_t;
  rcp_st_t s_q, s_d;
  logic [7:0] cmd_mem [CMD_MAX];
  logic [7:0] mem_rd_q;
  logic wr_en, tx_pop, fifo_valid, tick, term_hit;
  logic [7:0] wr_byte, fifo_data, rx_byte;
  logic [3:0] nb;
  logic [5:0] stop_ticks;
  rcp_par_t par;
  rcp_term_t term;

  function automatic logic [3:0] nbits(input logic [1:0] f);
    return (f == 2'h0) ? 4'd6 : (f == 2'h1) ? 4'd7 : 4'd8;
  endfunction

  function automatic logic par_bit(input logic [7:0] b, input rcp_par_t p);
    return (p == PAR_ODD) ? ~^b : ^b;
  endfunction

  rcp_fifo #(.W(8), .D(FIFO_DEPTH)) u_txf (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_in_valid(i_wr && i_addr == REG_TXDATA),
    .o_in_ready(o_tx_ready),
    .i_in_data(i_wdata[7:0]),
    .o_out_valid(fifo_valid),
    .i_out_ready(tx_pop),
    .o_out_data(fifo_data)
  );

  always_comb begin
    s_d = s_q;
    wr_en = 1'b0;
    wr_byte = '0;
    term_hit = 1'b0;
    nb = nbits(s_q.cfg[CFG_DBITS +: 2]);
    par = rcp_par_t'(s_q.cfg[CFG_PAR +: 2]);
    term = rcp_term_t'(s_q.cfg[CFG_TERM +: 2]);
    stop_ticks = (s_q.cfg[CFG_STOP +: 2] == 2'h0) ? 6'd16 :
                 (s_q.cfg[CFG_STOP +: 2] == 2'h1) ? 6'd24 : 6'd32;
    rx_byte = s_q.rsh >> (4'd8 - nb);
    s_d.sync1 = i_rxd;
    s_d.sync2 = s_q.sync1;
    tick = s_q.tick_cnt == '0;
    s_d.tick_cnt = tick ? baud_div(s_q.cfg[CFG_BAUD +: 3]) :
                   s_q.tick_cnt - 8'h01;
    // a pending setting blocks new transmit frames so it cannot starve
    tx_pop = fifo_valid && s_q.tst == TX_IDLE && !s_q.pend &&
             s_q.cfg[CFG_IF +: 2] == IF_SERIAL;
    // register port
    s_d.rd_sel = i_rd && i_addr == REG_RXDATA;
    s_d.rdata = '0;
    if (i_rd) begin
      case (i_addr)
        REG_CFG: s_d.rdata = 32'(s_q.cfg);
        REG_STAT: begin
          s_d.rdata[ST_READY] = s_q.ready;
          s_d.rdata[ST_PERR] = s_q.perr;
          s_d.rdata[ST_FERR] = s_q.ferr;
          s_d.rdata[ST_OVF] = s_q.ovf;
          s_d.rdata[ST_OVR] = s_q.ovr;
          s_d.rdata[ST_TXBUSY] = s_q.tst != TX_IDLE || fifo_valid;
          s_d.rdata[ST_RXBUSY] = s_q.rst != RX_IDLE;
          s_d.rdata[ST_TXFULL] = !o_tx_ready;
          s_d.rdata[ST_PEND] = s_q.pend;
        end
        REG_RXLEN: s_d.rdata = 32'(s_q.len);
        REG_RXDATA: s_d.rd_ptr = s_q.rd_ptr + 12'h001;
        default: s_d.rdata = '0;
      endcase
    end
    if (i_wr) begin
      case (i_addr)
        REG_CFG: begin
          s_d.cfg_new = i_wdata[CFG_W-1:0];
          s_d.pend = 1'b1;
        end
        REG_STAT: begin
          // write one to clear; a set later in this cycle still wins
          if (i_wdata[ST_PERR]) s_d.perr = 1'b0;
          if (i_wdata[ST_FERR]) s_d.ferr = 1'b0;
          if (i_wdata[ST_OVF]) s_d.ovf = 1'b0;
          if (i_wdata[ST_OVR]) s_d.ovr = 1'b0;
        end
        REG_CTRL: begin
          if (i_wdata[CTRL_RELEASE]) begin
            s_d.ready = 1'b0;
            s_d.len = '0;
            s_d.rd_ptr = '0;
          end
        end
        default: ;
      endcase
    end
    if (s_q.pend && s_q.rst == RX_IDLE && s_q.tst == TX_IDLE) begin
      s_d.cfg = s_q.cfg_new;
      s_d.pend = 1'b0;
      // restart the divider so a faster rate never sees a stale count
      s_d.tick_cnt = '0;
    end
    // transmitter
    case (s_q.tst)
      TX_IDLE: begin
        s_d.txd = 1'b1;
        if (tx_pop) begin
          s_d.tsh = fifo_data;
          s_d.tpar = par_bit(fifo_data & ~(8'hff << nb), par);
          s_d.tst = TX_START;
          s_d.tcnt = '0;
          s_d.txd = 1'b0;
        end
      end
      TX_START, TX_DATA, TX_PAR: begin
        if (tick) begin
          s_d.tcnt = s_q.tcnt + 6'h01;
          if (s_q.tcnt == 6'd15) begin
            s_d.tcnt = '0;
            if (s_q.tst == TX_START) begin
              s_d.tst = TX_DATA;
              s_d.tbit = '0;
              s_d.txd = s_q.tsh[0];
            end else if (s_q.tst == TX_DATA && s_q.tbit != nb - 4'd1) begin
              s_d.tbit = s_q.tbit + 4'd1;
              s_d.tsh = s_q.tsh >> 1;
              s_d.txd = s_q.tsh[1];
            end else if (s_q.tst == TX_DATA && par != PAR_NONE) begin
              s_d.tst = TX_PAR;
              s_d.txd = s_q.tpar;
            end else begin
              s_d.tst = TX_STOP;
              s_d.txd = 1'b1;
            end
          end
        end
      end
      TX_STOP: begin
        if (tick) begin
          s_d.tcnt = s_q.tcnt + 6'h01;
          if (s_q.tcnt == stop_ticks - 6'd1) begin
            s_d.tst = TX_IDLE;
          end
        end
      end
      default: s_d.tst = TX_IDLE;
    endcase
    // receiver: counts run from the middle of each bit
    case (s_q.rst)
      RX_IDLE: begin
        if (!s_q.sync2 && s_q.cfg[CFG_IF +: 2] == IF_SERIAL) begin
          s_d.rst = RX_START;
          s_d.rcnt = '0;
          s_d.rferr = 1'b0;
        end
      end
      RX_START: begin
        if (tick) begin
          s_d.rcnt = s_q.rcnt + 6'h01;
          if (s_q.rcnt == 6'd7) begin
            s_d.rcnt = '0;
            s_d.rbit = '0;
            s_d.rst = s_q.sync2 ? RX_IDLE : RX_DATA;
          end
        end
      end
      RX_DATA, RX_PAR: begin
        if (tick) begin
          s_d.rcnt = s_q.rcnt + 6'h01;
          if (s_q.rcnt == 6'd15) begin
            s_d.rcnt = '0;
            if (s_q.rst == RX_PAR) begin
              s_d.rpar = s_q.sync2;
              s_d.rst = RX_STOP;
            end else begin
              s_d.rsh = {s_q.sync2, s_q.rsh[7:1]};
              s_d.rbit = s_q.rbit + 4'd1;
              if (s_q.rbit == nb - 4'd1) begin
                s_d.rst = (par != PAR_NONE) ? RX_PAR : RX_STOP;
              end
            end
          end
        end
      end
      RX_STOP: begin
        if (tick) begin
          s_d.rcnt = s_q.rcnt + 6'h01;
          if ((s_q.rcnt == 6'd15 || (stop_ticks == 6'd32 &&
              s_q.rcnt == 6'd31)) && !s_q.sync2) begin
            s_d.rferr = 1'b1;
          end
          if (s_q.rcnt == stop_ticks - 6'd1) begin
            s_d.rst = RX_IDLE;
            if (s_d.rferr) begin
              s_d.ferr = 1'b1;
            end else if (par != PAR_NONE &&
                         par_bit(rx_byte, par) != s_q.rpar) begin
              s_d.perr = 1'b1;
            end else if (s_q.ready) begin
              s_d.ovr = 1'b1;
            end else begin
              s_d.prev_cr = rx_byte == CH_CR;
              term_hit = (term == TERM_LF && rx_byte == CH_LF) ||
                (term == TERM_CR && rx_byte == CH_CR) ||
                (term == TERM_CR_LF && rx_byte == CH_LF &&
                 s_q.prev_cr);
              if (term_hit) begin
                s_d.ready = 1'b1;
                if (term == TERM_CR_LF) s_d.len = s_q.len - 12'h001;
              end else if (32'(s_q.len) == CMD_MAX) begin
                s_d.ovf = 1'b1;
                s_d.len = '0;
              end else begin
                wr_en = 1'b1;
                wr_byte = rx_byte;
                s_d.len = s_q.len + 12'h001;
              end
            end
          end
        end
      end
      default: s_d.rst = RX_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
      s_q.sync1 <= 1'b1;
      s_q.sync2 <= 1'b1;
      s_q.txd <= 1'b1;
      s_q.cfg <= CFG_RST;
      s_q.cfg_new <= CFG_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // the buffer is plain memory; its read data are muxed onto the port
  always_ff @(posedge i_clk_sys) begin
    if (wr_en) cmd_mem[s_q.len[10:0]] <= wr_byte;
    if (s_d.rd_sel) mem_rd_q <= cmd_mem[s_q.rd_ptr[10:0]];
  end

  assign o_rdata = s_q.rd_sel ? {24'h0, mem_rd_q} : s_q.rdata;
  assign o_txd = s_q.txd;
  assign o_cmd_ready = s_q.ready;
  assign o_if_serial = s_q.cfg[CFG_IF +: 2] == IF_SERIAL;
  assign o_if_usb = s_q.cfg[CFG_IF +: 2] == IF_USB;
  assign o_if_lan = !o_if_serial && !o_if_usb;
  assign o_usb_vserial = o_if_usb && !s_q.cfg[CFG_USB];
  assign o_usb_tmc = o_if_usb && s_q.cfg[CFG_USB];

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  AST_TICK_RANGE: assert property (
    s_q.tick_cnt <= baud_div(s_q.cfg[CFG_BAUD +: 3]))
    else $error("tick counter beyond divider");
  AST_CFG_IDLE: assert property (
    $changed(s_q.cfg) |-> $past(s_q.rst == RX_IDLE && s_q.tst == TX_IDLE))
    else $error("settings changed mid frame");
  AST_STOP_HIGH: assert property (
    s_q.tst == TX_STOP |-> o_txd)
    else $error("stop interval not high");
  AST_PAR_ONLY: assert property (
    $rose(s_q.tst == TX_PAR) |-> par != PAR_NONE && o_txd == s_q.tpar)
    else $error("parity bit wrong");
  AST_WIDTH: assert property (
    s_q.tst == TX_DATA |-> s_q.tbit < nb)
    else $error("too many data bits");
  AST_TERM: assert property (
    $rose(s_q.ready) |-> $past(rx_byte == CH_LF || rx_byte == CH_CR))
    else $error("command ended without terminator");
  AST_LEN: assert property (
    32'(s_q.len) <= CMD_MAX)
    else $error("command buffer overrun");
  AST_ONE_SRC: assert property (
    $onehot({o_if_serial, o_if_usb, o_if_lan}))
    else $error("not exactly one source");
  AST_USB_FN: assert property (
    o_if_usb |-> o_usb_vserial != o_usb_tmc)
    else $error("usb function not unique");
endmodule

// ===== verif/rcp_host_model.sv
// host computer model: frames bytes onto the port's receive line
`timescale 1ns/100ps
module rcp_host_model #(
  parameter int BIT_NS = 26042
) (
  output logic o_line,
  input wire logic i_line
);
  // idle mark, driven at time zero; three wires only, no handshake
  initial o_line = 1'b1;

  function automatic logic par_of(logic [7:0] d, int par);
    return (par == 1) ? ~^d : ^d;
  endfunction

  // start, data lsb first, optional parity, stop in half-bit units
  task automatic send(input logic [7:0] d, input int nb, input int par,
    input int halves, input bit bad);
    int i;
    o_line = 1'b0;
    #(BIT_NS);
    for (i = 0; i < nb; i++) begin
      o_line = d[i];
      #(BIT_NS);
    end
    if (par != 0) begin
      o_line = par_of(d, par) ^ bad;
      #(BIT_NS);
    end
    o_line = 1'b1;
    #(BIT_NS * halves / 2);
  endtask

  // body bytes then the selected terminator; never longer than 2k
  task automatic send_cmd(input logic [7:0] q[$], input int term,
    input int nb, input int par, input int halves);
    int i;
    for (i = 0; i < q.size() && i < 2048; i++) begin
      send(q[i], nb, par, halves, 1'b0);
    end
    if (term != 0) begin
      send(8'h0d, nb, par, halves, 1'b0);
    end
    if (term != 1) begin
      send(8'h0a, nb, par, halves, 1'b0);
    end
  endtask

  // samples mid-bit at the host's own rate, so a fast device drifts early
  task automatic recv(input int nb, input int par, output logic [7:0] d,
    output logic p, output logic ok);
    int i;
    d = 8'h00;
    p = 1'b0;
    @(negedge i_line);
    #(BIT_NS / 2);
    ok = ~i_line;
    for (i = 0; i < nb; i++) begin
      #(BIT_NS);
      d[i] = i_line;
    end
    if (par != 0) begin
      #(BIT_NS);
      p = i_line;
    end
    #(BIT_NS);
    ok = ok & i_line;
  endtask
endmodule

// ===== verif/rcp_top_tb.sv
// self-checking bench of the serial command port
`timescale 1ns/100ps
module rcp_top_tb;
  import rcp_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_rxd;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic o_txd, o_tx_ready, o_cmd_ready, o_if_serial, o_if_usb, o_if_lan;
  logic o_usb_vserial, o_usb_tmc;
  logic [31:0] o_rdata;
  logic [31:0] seed = 32'h5031;
  int failures = 0;
  int num_checks = 0;

  always #50 i_clk_sys = ~i_clk_sys;

  rcp_top u_rcp_top (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_rxd(i_rxd),
    .o_txd(o_txd),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .o_tx_ready(o_tx_ready),
    .o_cmd_ready(o_cmd_ready),
    .o_if_serial(o_if_serial),
    .o_if_usb(o_if_usb),
    .o_if_lan(o_if_lan),
    .o_usb_vserial(o_usb_vserial),
    .o_usb_tmc(o_usb_tmc)
  );

  rcp_host_model u_rcp_host_model (
    .o_line(i_rxd),
    .i_line(o_txd)
  );

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] cfg(int rate, int bsel, int ssel,
    int par, int term, int src, int usb);
    return 32'(rate | bsel << 3 | ssel << 5 | par << 7 | term << 9 |
      src << 11 | usb << 13);
  endfunction

  function automatic logic [7:0] mask(int nb);
    return 8'((1 << nb) - 1);
  endfunction

  function automatic logic epar(logic [7:0] d, int par);
    return (par == 1) ? ~^d : ^d;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1;
    v = o_rdata;
  endtask

  // settings apply only between frames, so give the idle port a moment
  task automatic setcfg(input logic [31:0] v);
    logic [31:0] d;
    int i;
    wr(REG_CFG, v);
    // a frame still in its stop interval holds the setting back
    for (i = 0; i < 400; i++) begin
      rd(REG_STAT, d);
      if (d[ST_PEND] === 1'b0) break;
    end
    rd(REG_CFG, d);
    chk(d, v);
  endtask

  task automatic wait_ready();
    int i;
    for (i = 0; i < 3000 && o_cmd_ready !== 1'b1; i++) begin
      @(posedge i_clk_sys);
    end
    chk(32'(o_cmd_ready), 32'h1);
  endtask

  // about 24 frames of 12 bits at 38400 plus margin
  initial begin
    #(9_500_000);
    failures++;
    report_and_stop();
  end

  initial begin
    logic [31:0] d;
    logic [7:0] b, rb;
    logic p, ok;
    logic [7:0] q[$];
    logic [7:0] txq[$];
    int m, i, nb, par;
    repeat (12) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    #1;
    chk(32'({o_txd, o_cmd_ready, o_tx_ready, o_if_serial, o_if_usb,
      o_if_lan}), 32'h2c);
    rd(REG_CFG, d);
    chk(d, 32'h11);
    rd(8'h18, d);
    chk(d, 32'h0);
    for (m = 0; m < 5; m++) begin
      setcfg(cfg(m, 2, 0, 0, 0, 0, 0));
    end
    $display("rates done");
    // 115200 runs fast by rounding, so frames are exercised at 38400
    for (m = 0; m < 3; m++) begin
      nb = 6 + m;
      par = (m + 1) % 3;
      setcfg(cfg(3, m, m, par, m, 0, 0));
      q = {};
      for (i = 0; i < 2; i++) begin
        q.push_back(8'h20 | (8'(rnd()) & mask(nb)));
      end
      u_rcp_host_model.send_cmd(q, m, nb, par, 2 + m);
      wait_ready();
      rd(REG_RXLEN, d);
      chk(d, 32'(q.size()));
      for (i = 0; i < 2; i++) begin
        rd(REG_RXDATA, d);
        chk(d & 32'hff, 32'(q[i]));
      end
      wr(REG_CTRL, 32'h1);
      chk(32'(o_cmd_ready), 32'h0);
      b = 8'(rnd()) & mask(nb);
      fork
        u_rcp_host_model.recv(nb, par, rb, p, ok);
        wr(REG_TXDATA, 32'(b));
      join
      chk(32'({rb, p, ok}), 32'({b, (par == 0) ? 1'b0 : epar(b, par),
        1'b1}));
      $display("mode %0d done", m);
    end
    setcfg(cfg(3, 2, 0, 1, 0, 0, 0));
    u_rcp_host_model.send(8'h55, 8, 1, 2, 1'b1);
    repeat (10) @(posedge i_clk_sys);
    rd(REG_STAT, d);
    chk(d & 32'h3, 32'h2);
    wr(REG_STAT, 32'h2);
    rd(REG_STAT, d);
    chk(d & 32'h2, 32'h0);
    $display("parity done");
    // while another source is active the transmit queue only fills
    setcfg(cfg(3, 2, 0, 0, 0, 1, 0));
    chk(32'({o_if_serial, o_if_usb, o_if_lan, o_usb_vserial, o_usb_tmc}),
      32'h0a);
    for (i = 0; i < 9; i++) begin
      b = 8'(rnd());
      if (i < 8) begin
        txq.push_back(b);
      end
      wr(REG_TXDATA, 32'(b));
    end
    chk(32'(o_tx_ready), 32'h0);
    rd(REG_STAT, d);
    chk(d & 32'h80, 32'h80);
    setcfg(cfg(3, 2, 0, 0, 0, 1, 1));
    chk(32'({o_if_serial, o_if_usb, o_if_lan, o_usb_vserial, o_usb_tmc}),
      32'h09);
    setcfg(cfg(3, 2, 0, 0, 0, 2, 0));
    chk(32'({o_if_serial, o_if_usb, o_if_lan, o_usb_vserial, o_usb_tmc}),
      32'h04);
    fork
      begin
        for (i = 0; i < 8; i++) begin
          u_rcp_host_model.recv(8, 0, rb, p, ok);
          chk(32'({rb, ok}), 32'({txq[i], 1'b1}));
        end
      end
      setcfg(cfg(3, 2, 0, 0, 0, 0, 0));
    join
    chk(32'(o_tx_ready), 32'h1);
    $display("fifo done");
    report_and_stop();
  end
endmodule
